// ---- include/usf_params.svh ----
// Constants for the status flag logic: flag positions, widths, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef USF_PARAMS_SVH
`define USF_PARAMS_SVH
// Host flag bit positions in o_host_flags.
`define USF_H_SETUP 0
`define USF_H_IN 1
`define USF_H_OUT 2
`define USF_H_LPM 3
`define USF_H_TOGGLE 4
`define USF_H_NAK 5
`define USF_H_SPLIT 6
`define USF_NHOST 7
// Device-mode flag count and endpoint width.
`define USF_NDEV 7
`define USF_EPW 4
`define USF_QDEPTH 16
`define USF_QAW 4
// Status word layout: flags in the low bits, endpoint above them.
`define USF_WORD_EP_LSB 8
`define USF_WORD_W 16
`define USF_FLAGS_RST 7'h00
`endif

// ---- include/usf_pkg.sv ----
// Types shared by the status flag logic.
// Assumes the params header is on the include path.
`include "usf_params.svh"
package usf_pkg;
  typedef struct packed {
    logic [`USF_EPW-1:0] ep;
    logic [`USF_NDEV-1:0] flag;
  } usf_entry_t;
  typedef enum logic [1:0] {
    USF_IDLE = 2'b01,
    USF_SHOW = 2'b10
  } usf_head_t;
endpackage

// ---- hdl/usf_queue_mem.sv ----
// Small memory for queued device-mode status entries.
// Assumes one write and one registered read port on i_clk.
`timescale 1ns/1ps
`include "usf_params.svh"
module usf_queue_mem #(
  parameter int AW = `USF_QAW,
  parameter int DW = `USF_EPW + `USF_NDEV
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule

// ---- hdl/usf_status_flags.sv ----
// Transaction status flags of the serial interface engine, host and device.
// Assumes events are single-cycle pulses synchronous to i_clk.
`timescale 1ns/1ps
`include "usf_params.svh"
module usf_status_flags #(
  parameter int QAW = `USF_QAW
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_host_mode,
  input wire logic i_script_start,
  input wire logic i_setup_sent,
  input wire logic i_in_rcvd,
  input wire logic i_in_stall,
  input wire logic i_in_toggle_bad,
  input wire logic i_out_sent,
  input wire logic i_lpm_sent,
  input wire logic i_nak_valid,
  input wire logic i_no_retry,
  input wire logic i_csplit_err,
  input wire logic [`USF_NHOST-1:0] i_host_clr,
  input wire logic i_dev_ev,
  input wire usf_pkg::usf_entry_t i_dev_entry,
  input wire logic [`USF_NDEV-1:0] i_dev_clr,
  input wire logic i_status_wr,
  output logic [`USF_NHOST-1:0] o_host_flags,
  output logic [`USF_NDEV-1:0] o_dev_flags,
  output logic [`USF_WORD_W-1:0] o_status_queue_word,
  output logic o_queue_full
);
  import usf_pkg::*;

  // ==========================================================
  // Host mode flags
  logic block_done;
  logic [`USF_NHOST-1:0] host_set;
  always_comb begin
    block_done = (i_nak_valid && i_no_retry) || i_csplit_err;
    host_set = '0;
    if (i_host_mode) begin
      host_set[`USF_H_SETUP] = i_setup_sent && !block_done;
      host_set[`USF_H_IN] = i_in_rcvd && !i_in_stall && !i_in_toggle_bad
                            && !block_done;
      host_set[`USF_H_OUT] = i_out_sent && !block_done;
      host_set[`USF_H_LPM] = i_lpm_sent;
      host_set[`USF_H_TOGGLE] = i_in_rcvd && i_in_toggle_bad;
      host_set[`USF_H_NAK] = i_nak_valid && i_no_retry;
      host_set[`USF_H_SPLIT] = i_csplit_err;
    end
  end

  // direct sticky flags
  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_host_flags <= '0;
    end else if (i_ce) begin
      if (i_script_start) begin
        o_host_flags <= '0;
      end else begin
        o_host_flags <= (o_host_flags & ~i_host_clr) | host_set;
      end
    end
  end

  // ==========================================================
  // Device mode queue
  logic [QAW:0] wr_ptr;
  logic [QAW:0] rd_ptr;
  logic [QAW:0] count;
  logic push;
  logic pop;
  logic flush;
  logic mem_valid;
  usf_entry_t head;
  usf_entry_t mem_rdata;
  usf_head_t hstate;
  logic [QAW-1:0] next_raddr;

  assign count = wr_ptr - rd_ptr;
  assign o_queue_full = count[QAW];
  assign flush = i_status_wr || i_script_start;
  assign push = !i_host_mode && i_dev_ev && !o_queue_full && !flush;
  assign pop = (hstate == USF_SHOW) && |(i_dev_clr & head.flag) && !flush;

  // The memory read lags one cycle, so the head register is loaded from
  // the entry at rd_ptr one cycle after it is known to be present.
  assign next_raddr = pop ? QAW'(rd_ptr + 1'b1) : rd_ptr[QAW-1:0];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (i_ce) begin
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (push) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
      end
    end
  end

  // Read data is valid when an entry sat at the read address last cycle.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mem_valid <= 1'b0;
    end else if (i_ce) begin
      mem_valid <= !flush && (next_raddr != wr_ptr[QAW-1:0]
                   || (count != '0 && !pop) || count > 1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hstate <= USF_IDLE;
      head <= '0;
    end else if (i_ce) begin
      case (hstate)
        USF_IDLE: begin
          if (!flush && mem_valid && count != '0) begin
            hstate <= USF_SHOW;
            head <= mem_rdata;
          end
        end
        USF_SHOW: begin
          if (flush || pop) begin
            hstate <= USF_IDLE;
            head <= '0;
          end
        end
        default: begin
          hstate <= USF_IDLE;
          head <= '0;
        end
      endcase
    end
  end

  usf_queue_mem #(
    .AW(QAW),
    .DW(`USF_EPW + `USF_NDEV)
  ) u_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(push),
    .i_waddr(wr_ptr[QAW-1:0]),
    .i_wdata(i_dev_entry),
    .i_raddr(next_raddr),
    .o_rdata(mem_rdata)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dev_flags <= `USF_FLAGS_RST;
      o_status_queue_word <= '0;
    end else if (i_ce) begin
      if (hstate == USF_SHOW && !flush && !pop) begin
        o_dev_flags <= head.flag;
        o_status_queue_word <= '0;
        o_status_queue_word[`USF_NDEV-1:0] <= head.flag;
        o_status_queue_word[`USF_WORD_EP_LSB +: `USF_EPW] <= head.ep;
      end else begin
        o_dev_flags <= `USF_FLAGS_RST;
        o_status_queue_word <= '0;
      end
    end
  end

  // ==========================================================
  // Checks
  // Each check watches what the block drives; events count only with the
  // clock enable high, since a frozen cycle changes nothing.
  host_direct_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_host_mode && i_setup_sent && !block_done && !i_script_start
    |=> o_host_flags[`USF_H_SETUP])
    else $error("setup flag not raised");
  in_stall_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_in_rcvd && i_in_stall && !o_host_flags[`USF_H_IN]
    |=> !o_host_flags[`USF_H_IN])
    else $error("in flag set on stall");
  out_sent_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_host_mode && i_out_sent && !block_done && !i_script_start
    |=> o_host_flags[`USF_H_OUT])
    else $error("out flag not raised");
  lpm_sent_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_host_mode && i_lpm_sent && !i_script_start
    |=> o_host_flags[`USF_H_LPM])
    else $error("lpm flag not raised");
  toggle_bad_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_host_mode && i_in_rcvd && i_in_toggle_bad && !i_script_start
    |=> o_host_flags[`USF_H_TOGGLE])
    else $error("toggle mismatch not raised");
  in_toggle_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_in_rcvd && i_in_toggle_bad && !o_host_flags[`USF_H_IN]
    |=> !o_host_flags[`USF_H_IN])
    else $error("in flag set on bad toggle");
  nak_block_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && block_done && (o_host_flags[2:0] & ~i_host_clr[2:0]) == 3'h0
    |=> o_host_flags[2:0] == 3'h0)
    else $error("completion set with nak or split error");
  nak_flag_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_host_mode && i_nak_valid && i_no_retry && !i_script_start
    |=> o_host_flags[`USF_H_NAK])
    else $error("nak flag not raised");
  split_err_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_host_mode && i_csplit_err && !i_script_start
    |=> o_host_flags[`USF_H_SPLIT])
    else $error("split error not raised");
  host_hold_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && !i_script_start && (o_host_flags & ~i_host_clr) != '0
    |=> (o_host_flags & $past(o_host_flags & ~i_host_clr))
        == $past(o_host_flags & ~i_host_clr))
    else $error("host flag dropped");
  dev_quiet_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && !i_host_mode && o_host_flags == '0
    |=> o_host_flags == '0)
    else $error("host flag set in device mode");
  start_clear_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_script_start |=> o_host_flags == '0 && count == '0
    && o_dev_flags == '0)
    else $error("flags not cleared at start");
  flush_q_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && i_status_wr |=> count == '0 ##1 o_status_queue_word == '0)
    else $error("status write did not empty queue");
  head_hold_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && hstate == USF_SHOW && !pop && !flush
    |=> hstate == USF_SHOW && $stable(head))
    else $error("queue advanced without head clear");
  pop_step_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && pop |=> rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("queue did not advance by one");
  clear_other_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && !flush && (i_dev_clr & head.flag) == '0 |=> $stable(rd_ptr))
    else $error("queue advanced on a foreign clear");
  word_show_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && hstate == USF_SHOW && !pop && !flush
    |=> o_status_queue_word[`USF_WORD_EP_LSB +: `USF_EPW]
        == $past(head.ep))
    else $error("status word endpoint wrong");
  idle_word_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && hstate != USF_SHOW |=> o_status_queue_word == '0)
    else $error("status word shown with empty head");
  // An overfilled queue would wrap the pointers and silently reorder the
  // entries, so the count must never pass the depth.
  count_bound_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    count <= (1 << QAW))
    else $error("queue count past depth");
  full_drop_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    i_ce && o_queue_full && !flush |=> $stable(wr_ptr))
    else $error("write into full queue");
  head_order_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    (i_ce && push && count == '0) ##1 (i_ce && !flush) ##1 (i_ce && !flush)
    |=> head == $past(i_dev_entry, 3))
    else $error("head is not the oldest entry");
endmodule

// ---- bench/usf_uut_model.sv ----
// Model of the unit under test: turns a named outcome into event pulses.
// Assumes the bench pulses i_go for one cycle with i_kind held steady.
`timescale 1ns/1ps
module usf_uut_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [2:0] i_kind,
  output logic o_setup,
  output logic o_in,
  output logic o_stall,
  output logic o_tog,
  output logic o_out,
  output logic o_lpm,
  output logic o_nak,
  output logic o_err
);
  // ====================
  // Outcome pulses
  // A stall, bad toggle or split error still ends the in phase, so the
  // engine, not this model, must hold the completion back.
  always_ff @(posedge i_clk) begin
    o_setup <= i_go && i_kind == 3'h0;
    o_in <= i_go && (i_kind inside {3'h1, 3'h2, 3'h3, 3'h7});
    o_stall <= i_go && i_kind == 3'h2;
    o_tog <= i_go && i_kind == 3'h3;
    o_out <= i_go && (i_kind inside {3'h4, 3'h6});
    o_lpm <= i_go && i_kind == 3'h5;
    o_nak <= i_go && i_kind == 3'h6;
    o_err <= i_go && i_kind == 3'h7;
  end
endmodule

// ---- bench/tb_usb_engine_status_flags.sv ----
// Bench for the status flags: host outcomes and the device queue.
// Assumes the design, the package and the bus model share one compile.
`timescale 1ns/1ps
module tb_usb_engine_status_flags;
  import usf_pkg::*;
  logic i_clk = 0, i_srst = 1, i_host_mode = 1, i_script_start = 0;
  logic i_no_retry = 1, i_dev_ev = 0, i_status_wr = 0, go = 0, i_ce = 1;
  logic [2:0] kind = 0;
  logic [6:0] i_host_clr = 0, i_dev_clr = 0, o_host_flags, o_dev_flags;
  usf_entry_t i_dev_entry = '0;
  logic [15:0] o_status_queue_word;
  logic s, in, st, tg, o, l, n, e, full;
  int bad_count = 0, total_checks = 0;
  usf_uut_model bus (.i_clk(i_clk), .i_go(go), .i_kind(kind),
    .o_setup(s), .o_in(in), .o_stall(st), .o_tog(tg), .o_out(o),
    .o_lpm(l), .o_nak(n), .o_err(e));
  usf_status_flags dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_host_mode(i_host_mode), .i_script_start(i_script_start),
    .i_setup_sent(s), .i_in_rcvd(in), .i_in_stall(st),
    .i_in_toggle_bad(tg), .i_out_sent(o), .i_lpm_sent(l),
    .i_nak_valid(n), .i_no_retry(i_no_retry), .i_csplit_err(e),
    .i_host_clr(i_host_clr), .i_dev_ev(i_dev_ev),
    .i_dev_entry(i_dev_entry), .i_dev_clr(i_dev_clr),
    .i_status_wr(i_status_wr), .o_host_flags(o_host_flags),
    .o_dev_flags(o_dev_flags), .o_status_queue_word(o_status_queue_word),
    .o_queue_full(full));
  // ====================
  // Helpers
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic close_out;
    $display("Checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic host_outcomes;
    logic [6:0] exp [8] = '{7'h01, 7'h02, 7'h00, 7'h10, 7'h04, 7'h08,
      7'h20, 7'h40};
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk);
      i_script_start <= 1;
      kind <= k[2:0];
      go <= 1;
      @(posedge i_clk);
      i_script_start <= 0;
      go <= 0;
      tick(4);
      chk({9'h0, o_host_flags}, {9'h0, exp[k]});
      tick(9);
      chk({9'h0, o_host_flags}, {9'h0, exp[k]});
      @(posedge i_clk);
      i_host_clr <= exp[k];
      @(posedge i_clk);
      i_host_clr <= 0;
      tick(2);
      chk({9'h0, o_host_flags}, 16'h0);
    end
  endtask
  task automatic dev_order;
    @(posedge i_clk);
    i_host_mode <= 0;
    for (int k = 1; k < 4; k++) begin
      i_dev_ev <= 1;
      i_dev_entry <= '{ep: k[3:0], flag: 7'h01 << (k - 1)};
      @(posedge i_clk);
    end
    i_dev_ev <= 0;
    go <= 1;
    @(posedge i_clk);
    go <= 0;
    for (int k = 1; k < 4; k++) begin
      tick(6);
      chk(o_status_queue_word, {4'h0, k[3:0], 8'h01 << (k - 1)});
      chk({9'h0, o_dev_flags}, {9'h0, 7'h01 << (k - 1)});
      @(posedge i_clk);
      i_dev_clr <= 7'h01 << (k - 1);
      @(posedge i_clk);
      i_dev_clr <= 0;
    end
    tick(6);
    chk({9'h0, o_host_flags}, 16'h0);
    chk(o_status_queue_word, 16'h0);
  endtask
  task automatic dev_flush;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_dev_ev <= 1;
      i_dev_entry <= '{ep: 4'hf, flag: 7'h40};
      @(posedge i_clk);
      i_dev_ev <= 0;
      tick(6);
      chk(o_status_queue_word, 16'h0f40);
      // empty by a write, then by script start
      @(posedge i_clk);
      i_status_wr <= (k == 0);
      i_script_start <= (k == 1);
      @(posedge i_clk);
      i_status_wr <= 0;
      i_script_start <= 0;
      tick(8);
      chk(o_status_queue_word, 16'h0);
    end
  endtask
  task automatic dev_full;
    @(posedge i_clk);
    i_dev_ev <= 1;
    i_dev_entry <= '{ep: 4'h5, flag: 7'h02};
    repeat (17) @(posedge i_clk);
    i_dev_ev <= 0;
    tick(4);
    chk({15'h0, full}, 16'h1);
    chk(o_status_queue_word, 16'h0502);
    // A write while the clock enable is low must be lost.
    @(posedge i_clk);
    i_ce <= 0;
    i_status_wr <= 1;
    @(posedge i_clk);
    i_ce <= 1;
    i_status_wr <= 0;
    tick(2);
    chk({15'h0, full}, 16'h1);
    @(posedge i_clk);
    i_status_wr <= 1;
    @(posedge i_clk);
    i_status_wr <= 0;
    tick(2);
    chk({15'h0, full}, 16'h0);
  endtask
  // ====================
  // Sequence and watchdog
  initial begin
    repeat (3) @(posedge i_clk);
    i_srst <= 0;
    host_outcomes();
    dev_order();
    dev_flush();
    dev_full();
    close_out();
  end
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule
